// ===== core/spiopt_core.sv
// spi shifter with option control register, status and interrupts
`timescale 1ns/1ps
`default_nettype none
module spiopt_core (
	input  wire logic       i_ref_clk,
	input  wire logic       i_arst_n,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wr_data,
	input  wire logic       i_wr_en,
	input  wire logic       i_rd_en,
	output logic      [7:0] o_rd_data,
	output logic            o_irq,
	output logic            o_tx_dma_req,
	input  wire logic       i_sclk,
	output logic            o_sclk,
	output logic            o_sclk_oe,
	input  wire logic       i_mosi,
	output logic            o_mosi,
	output logic            o_mosi_oe,
	input  wire logic       i_miso,
	output logic            o_miso,
	output logic            o_miso_oe,
	input  wire logic       i_ss_n,
	output logic            o_ss_n,
	output logic            o_ss_oe,
	output logic            o_ss_gpio
);
	import spiopt_pkg::*;

	typedef struct packed {
		spiopt_state_e state;
		logic [7:0]    control;
		logic [7:0]    option;
		logic [15:0]   match;
		logic [15:0]   tx_buf;
		logic [15:0]   rx_buf;
		logic [15:0]   shift;
		logic [4:0]    bit_cnt;
		logic [3:0]    half_cnt;
		logic          sclk;
		logic          in_bit;
		logic          out_bit;
		logic          ss_n;
		logic          rx_full;
		logic          match_flag;
		logic          tx_empty;
		logic          modf;
		logic [3:0]    irq_st;
		logic [3:0]    irq_mask;
		logic [7:0]    rd_data;
		logic          sclk_prev;
		logic          ss_prev;
	} spiopt_core_s;

	localparam spiopt_core_s CORE_RST = '{
		state:      SPIOPT_IDLE,
		control:    CONTROL_RST,
		option:     OPTION_RST,
		match:      MATCH_RST,
		tx_buf:     16'h0000,
		rx_buf:     16'h0000,
		shift:      16'h0000,
		bit_cnt:    5'h00,
		half_cnt:   4'h0,
		sclk:       1'b0,
		in_bit:     1'b0,
		out_bit:    1'b0,
		ss_n:       1'b1,
		rx_full:    1'b0,
		match_flag: 1'b0,
		tx_empty:   TX_EMPTY_RST,
		modf:       1'b0,
		irq_st:     4'h0,
		irq_mask:   IRQ_MASK_RST,
		rd_data:    8'h00,
		sclk_prev:  1'b0,
		ss_prev:    1'b0
	};

	spiopt_core_s core_reg;
	spiopt_core_s core_next;

	logic [SYNC_W-1:0] pins_async;
	logic [SYNC_W-1:0] pins_sync;
	logic              sclk_s;
	logic              mosi_s;
	logic              miso_s;
	logic              ss_s;
	logic              enable;
	logic              master;
	logic              select_output_enable;
	logic              wide;
	logic              modf_en;
	logic              sclk_rise;
	logic              ss_fall;
	logic              fault_in;
	logic              width_flip;
	logic [4:0]        last_bit;
	logic [3:0]        irq_gate;
	logic [7:0]        status_view;

	assign pins_async[SY_SCLK] = i_sclk;
	assign pins_async[SY_MOSI] = i_mosi;
	assign pins_async[SY_MISO] = i_miso;
	assign pins_async[SY_SS]   = i_ss_n;

	spiopt_sync u_sync (
		.i_ref_clk (i_ref_clk),
		.i_arst_n  (i_arst_n),
		.i_async   (pins_async),
		.o_sync    (pins_sync)
	);

	assign sclk_s  = pins_sync[SY_SCLK];
	assign mosi_s  = pins_sync[SY_MOSI];
	assign miso_s  = pins_sync[SY_MISO];
	assign ss_s    = pins_sync[SY_SS];

	assign enable  = core_reg.control[CTL_ENABLE];
	assign master  = core_reg.control[CTL_MASTER];
	assign select_output_enable    = core_reg.control[CTL_SELECT_OUTPUT_ENABLE];
	assign wide    = core_reg.option[OPT_WIDTH];
	assign modf_en = core_reg.option[OPT_MODF];

	assign sclk_rise = sclk_s && !core_reg.sclk_prev;
	assign ss_fall   = !ss_s && core_reg.ss_prev;
	// ss low seen as fault input only in this pin mode
	assign fault_in  = enable && master && modf_en && !select_output_enable && !ss_s;
	assign last_bit  = wide ? LAST_BIT_WIDE : LAST_BIT_NARROW;
	assign width_flip = i_wr_en && (i_addr == OFS_OPTION) && master &&
		(i_wr_data[OPT_WIDTH] != wide);

	assign status_view = {core_reg.rx_full, core_reg.match_flag,
		core_reg.tx_empty, core_reg.modf, 4'h0};

	// per-source gating applied after the sticky bits
	assign irq_gate[IRQ_RX]    = 1'b1;
	assign irq_gate[IRQ_TX]    = !core_reg.option[OPT_TXDMA];
	assign irq_gate[IRQ_MATCH] = core_reg.option[OPT_MATCH_IE];
	assign irq_gate[IRQ_MODF]  = 1'b1;

	always_comb begin
		logic ev_rx;
		logic ev_tx;
		logic ev_match;
		logic ev_modf;
		ev_rx    = 1'b0;
		ev_tx    = 1'b0;
		ev_match = 1'b0;
		ev_modf  = 1'b0;
		core_next           = core_reg;
		core_next.sclk_prev = sclk_s;
		core_next.ss_prev   = ss_s;

		// read port: data valid only in the cycle after the strobe
		core_next.rd_data = 8'h00;
		if (i_rd_en) begin
			case (i_addr)
				OFS_CONTROL:    core_next.rd_data = core_reg.control;
				OFS_OPTION:     core_next.rd_data = core_reg.option;
				OFS_STATUS:     core_next.rd_data = status_view;
				OFS_DATA_LO:    core_next.rd_data = core_reg.rx_buf[7:0];
				OFS_DATA_HI:    core_next.rd_data = core_reg.rx_buf[15:8];
				OFS_MATCH_LO:   core_next.rd_data = core_reg.match[7:0];
				OFS_MATCH_HI:   core_next.rd_data = core_reg.match[15:8];
				OFS_IRQ_STATUS: core_next.rd_data = {4'h0, core_reg.irq_st};
				OFS_IRQ_MASK:   core_next.rd_data = {4'h0, core_reg.irq_mask};
				default:        core_next.rd_data = 8'h00;
			endcase
		end

		// reads that consume state
		if (i_rd_en && (i_addr == OFS_DATA_LO)) begin
			core_next.rx_full = 1'b0;
		end
		if (i_rd_en && (i_addr == OFS_IRQ_STATUS)) begin
			core_next.irq_st = 4'h0;
		end

		// register writes
		if (i_wr_en) begin
			case (i_addr)
				OFS_CONTROL: begin
					core_next.control = i_wr_data;
				end
				OFS_OPTION: begin
					core_next.option = i_wr_data;
				end
				OFS_STATUS: begin
					// write one to clear the two software flags
					if (i_wr_data[ST_MATCH]) begin
						core_next.match_flag = 1'b0;
					end
					if (i_wr_data[ST_MODF]) begin
						core_next.modf = 1'b0;
					end
				end
				OFS_DATA_LO: begin
					core_next.tx_buf[7:0] = i_wr_data;
					core_next.tx_empty    = 1'b0;
				end
				OFS_DATA_HI: begin
					core_next.tx_buf[15:8] = i_wr_data;
				end
				OFS_MATCH_LO: begin
					core_next.match[7:0] = i_wr_data;
				end
				OFS_MATCH_HI: begin
					core_next.match[15:8] = i_wr_data;
				end
				OFS_IRQ_MASK: begin
					core_next.irq_mask = i_wr_data[3:0];
				end
				default: begin
				end
			endcase
		end

		// frame engine
		case (core_reg.state)
			SPIOPT_IDLE: begin
				core_next.sclk     = 1'b0;
				core_next.bit_cnt  = 5'h00;
				core_next.half_cnt = 4'h0;
				if (enable && master && !core_reg.tx_empty && !fault_in) begin
					core_next.shift    = core_reg.tx_buf;
					core_next.tx_empty = 1'b1;
					ev_tx              = 1'b1;
					core_next.state    = SPIOPT_SHIFT;
				end else if (enable && !master && ss_fall) begin
					// slave frames start on ss; ss is always an input here
					core_next.shift = core_reg.tx_buf;
					if (!core_reg.tx_empty) begin
						core_next.tx_empty = 1'b1;
						ev_tx              = 1'b1;
					end
					core_next.state = SPIOPT_SHIFT;
				end
			end
			SPIOPT_SHIFT: begin
				if (master) begin
					core_next.half_cnt = core_reg.half_cnt + 4'h1;
					if (core_reg.half_cnt == HALF_CYC - 4'h1) begin
						core_next.half_cnt = 4'h0;
						if (!core_reg.sclk) begin
							core_next.sclk   = 1'b1;
							core_next.in_bit = miso_s;
						end else begin
							core_next.sclk    = 1'b0;
							core_next.shift   = {core_reg.shift[14:0],
								core_reg.in_bit};
							core_next.bit_cnt = core_reg.bit_cnt + 5'h01;
							if (core_reg.bit_cnt == last_bit) begin
								core_next.state = SPIOPT_DONE;
							end
						end
					end
				end else if (ss_s) begin
					// ss released mid frame drops the partial word
					core_next.state = SPIOPT_IDLE;
				end else if (sclk_rise) begin
					core_next.shift   = {core_reg.shift[14:0], mosi_s};
					core_next.bit_cnt = core_reg.bit_cnt + 5'h01;
					if (core_reg.bit_cnt == last_bit) begin
						core_next.state = SPIOPT_DONE;
					end
				end
			end
			SPIOPT_DONE: begin
				core_next.sclk  = 1'b0;
				core_next.state = SPIOPT_IDLE;
				ev_rx           = 1'b1;
				if (wide) begin
					core_next.rx_buf = core_reg.shift;
					ev_match = (core_reg.shift == core_reg.match);
				end else begin
					core_next.rx_buf = {8'h00, core_reg.shift[7:0]};
					ev_match = (core_reg.shift[7:0] == core_reg.match[7:0]);
				end
			end
			default: begin
				core_next.state = SPIOPT_IDLE;
			end
		endcase

		if (!enable) begin
			core_next.state = SPIOPT_IDLE;
			core_next.sclk  = 1'b0;
		end

		// external master pulled ss low: drop to slave and flag it
		if (fault_in) begin
			ev_modf                       = 1'b1;
			core_next.control[CTL_MASTER] = 1'b0;
			core_next.state               = SPIOPT_IDLE;
			core_next.sclk                = 1'b0;
		end

		// hardware sets beat same-cycle software clears, except the master width change below
		if (ev_rx) begin
			core_next.rx_full = 1'b1;
		end
		if (ev_match) begin
			core_next.match_flag = 1'b1;
		end
		if (ev_modf) begin
			core_next.modf = 1'b1;
		end

		// width change in master mode restarts from a clean status
		if (width_flip) begin
			core_next.state      = SPIOPT_IDLE;
			core_next.sclk       = 1'b0;
			core_next.bit_cnt    = 5'h00;
			core_next.half_cnt   = 4'h0;
			core_next.rx_full    = 1'b0;
			core_next.match_flag = 1'b0;
			core_next.modf       = 1'b0;
			core_next.tx_empty   = TX_EMPTY_RST;
			ev_rx                = 1'b0;
			ev_match             = 1'b0;
			ev_modf              = 1'b0;
		end

		core_next.irq_st[IRQ_RX]    = core_next.irq_st[IRQ_RX] | ev_rx;
		core_next.irq_st[IRQ_TX]    = core_next.irq_st[IRQ_TX] | ev_tx;
		core_next.irq_st[IRQ_MATCH] = core_next.irq_st[IRQ_MATCH] | ev_match;
		core_next.irq_st[IRQ_MODF]  = core_next.irq_st[IRQ_MODF] | ev_modf;

		// pin data from flops; msb of the active frame width
		core_next.out_bit = core_next.option[OPT_WIDTH] ?
			core_next.shift[15] : core_next.shift[7];
		core_next.ss_n    = (core_next.state == SPIOPT_IDLE);
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			core_reg <= CORE_RST;
		end else begin
			core_reg <= core_next;
		end
	end

	assign o_rd_data    = core_reg.rd_data;
	assign o_irq        = |(core_reg.irq_st & core_reg.irq_mask & irq_gate);
	assign o_tx_dma_req = core_reg.option[OPT_TXDMA] && core_reg.tx_empty &&
		enable;

	assign o_sclk       = core_reg.sclk;
	assign o_sclk_oe    = enable && master;
	assign o_mosi       = core_reg.out_bit;
	assign o_mosi_oe    = enable && master;
	assign o_miso       = core_reg.out_bit;
	// synced ss lags the pin by two cycles; drive starts slightly late
	assign o_miso_oe    = enable && !master && !ss_s;

	// ss pin use depends on mode, fault enable and ss output enable
	assign o_ss_n       = core_reg.ss_n;
	assign o_ss_oe      = enable && master && modf_en && select_output_enable;
	assign o_ss_gpio    = master && !modf_en;
endmodule
`default_nettype wire

// ===== core/spiopt_pkg.sv
// shared constants and types for the spi option control block
package spiopt_pkg;

	// clocking and link timing
	localparam int unsigned CLK_PERIOD_NS  = 20;
	localparam int unsigned SCLK_PERIOD_NS = 160;
	localparam int unsigned HALF_CYC_INT   =
		(SCLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
	localparam logic [3:0]  HALF_CYC       =
		4'((HALF_CYC_INT < 1) ? 1 : HALF_CYC_INT);

	// synchroniser width: sclk, mosi, miso, ss
	localparam int unsigned SYNC_W = 4;
	localparam int unsigned SY_SCLK = 0;
	localparam int unsigned SY_MOSI = 1;
	localparam int unsigned SY_MISO = 2;
	localparam int unsigned SY_SS   = 3;

	// register offsets
	localparam logic [7:0] OFS_CONTROL    = 8'h00;
	localparam logic [7:0] OFS_OPTION     = 8'h02;
	localparam logic [7:0] OFS_STATUS     = 8'h03;
	localparam logic [7:0] OFS_DATA_LO    = 8'h04;
	localparam logic [7:0] OFS_DATA_HI    = 8'h05;
	localparam logic [7:0] OFS_MATCH_LO   = 8'h06;
	localparam logic [7:0] OFS_MATCH_HI   = 8'h07;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h09;

	// control register fields
	localparam int unsigned CTL_ENABLE = 7;
	localparam int unsigned CTL_MASTER = 4;
	localparam int unsigned CTL_SELECT_OUTPUT_ENABLE   = 1;

	// option control register fields
	localparam int unsigned OPT_MATCH_IE = 7;
	localparam int unsigned OPT_WIDTH    = 6;
	localparam int unsigned OPT_TXDMA    = 5;
	localparam int unsigned OPT_MODF     = 4;

	// status register fields
	localparam int unsigned ST_RX_FULL  = 7;
	localparam int unsigned ST_MATCH    = 6;
	localparam int unsigned ST_TX_EMPTY = 5;
	localparam int unsigned ST_MODF     = 4;

	// interrupt status and mask fields
	localparam int unsigned IRQ_RX    = 0;
	localparam int unsigned IRQ_TX    = 1;
	localparam int unsigned IRQ_MATCH = 2;
	localparam int unsigned IRQ_MODF  = 3;

	// values after reset
	localparam logic [7:0]  CONTROL_RST  = 8'h00;
	localparam logic [7:0]  OPTION_RST   = 8'h00;
	localparam logic [15:0] MATCH_RST    = 16'h0000;
	localparam logic [3:0]  IRQ_MASK_RST = 4'h0;
	localparam logic        TX_EMPTY_RST = 1'b1;

	// last bit index of a frame
	localparam logic [4:0] LAST_BIT_NARROW = 5'h07;
	localparam logic [4:0] LAST_BIT_WIDE   = 5'h0F;

	typedef enum logic [2:0] {
		SPIOPT_IDLE  = 3'b001,
		SPIOPT_SHIFT = 3'b010,
		SPIOPT_DONE  = 3'b100
	} spiopt_state_e;

endpackage

// ===== core/spiopt_sync.sv
// two flip-flop synchroniser for the spi pins
`timescale 1ns/1ps
`default_nettype none
module spiopt_sync (
	input  wire logic                        i_ref_clk,
	input  wire logic                        i_arst_n,
	input  wire logic [spiopt_pkg::SYNC_W-1:0] i_async,
	output logic      [spiopt_pkg::SYNC_W-1:0] o_sync
);
	import spiopt_pkg::*;

	typedef struct packed {
		logic [SYNC_W-1:0] meta;
		logic [SYNC_W-1:0] stable;
	} spiopt_sync_s;

	spiopt_sync_s sync_reg;
	spiopt_sync_s sync_next;

	// meta stage feeds only the stable stage
	always_comb begin
		sync_next        = sync_reg;
		sync_next.meta   = i_async;
		sync_next.stable = sync_reg.meta;
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign o_sync = sync_reg.stable;
endmodule
`default_nettype wire

// ===== verif/spiopt_chk.sv
// port assertions for the spi option control block
`timescale 1ns/1ps
`default_nettype none
module spiopt_chk (
	input wire logic       i_ref_clk,
	input wire logic       i_arst_n,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic       i_wr_en,
	input wire logic       i_rd_en,
	input wire logic [7:0] o_rd_data,
	input wire logic       o_irq,
	input wire logic       o_tx_dma_req,
	input wire logic       o_sclk,
	input wire logic       o_ss_n,
	input wire logic       o_ss_oe,
	input wire logic       o_ss_gpio
);
	import spiopt_pkg::*;
	logic [7:0] opt_sh, ctl_sh;
	logic [3:0] msk_sh;
	logic [4:0] rise_cnt;
	logic       sclk_q, ssn_q, ab_q, wopt, abort;
	assign wopt  = i_wr_en && i_addr == OFS_OPTION;
	assign abort = wopt && ctl_sh[CTL_MASTER]
		&& (i_wr_data[OPT_WIDTH] != opt_sh[OPT_WIDTH]);
	// shadows track software writes; mode fault is not modelled here
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			opt_sh   <= 8'h00;
			ctl_sh   <= 8'h00;
			msk_sh   <= 4'h0;
			rise_cnt <= 5'h00;
			sclk_q   <= 1'b0;
			ssn_q    <= 1'b1;
			ab_q     <= 1'b0;
		end else begin
			if (wopt) opt_sh <= i_wr_data;
			if (i_wr_en && i_addr == OFS_CONTROL) ctl_sh <= i_wr_data;
			if (i_wr_en && i_addr == OFS_IRQ_MASK) msk_sh <= i_wr_data[3:0];
			sclk_q <= o_sclk;
			ssn_q  <= o_ss_n;
			if (o_ss_n) rise_cnt <= 5'h00;
			else if (o_sclk && !sclk_q) rise_cnt <= rise_cnt + 5'h01;
			if (abort) ab_q <= 1'b1;
			else if (!o_ss_n && ssn_q) ab_q <= 1'b0;
		end
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);
	a_opt_readback: assert property (
		i_rd_en && i_addr == OFS_OPTION |=> o_rd_data == opt_sh)
		else $error("option register readback wrong");
	a_match_gate: assert property (
		!opt_sh[OPT_MATCH_IE] && msk_sh == 4'h4 |-> !o_irq)
		else $error("match interrupt not inhibited");
	// slave frames run on the far clock, so only master frames count
	a_frame_len: assert property (
		$rose(o_ss_n) && !ab_q && ctl_sh[CTL_ENABLE] && ctl_sh[CTL_MASTER]
		|-> rise_cnt == (opt_sh[OPT_WIDTH] ? 5'h10 : 5'h08))
		else $error("frame length wrong");
	a_width_abort: assert property (
		abort |-> ##2 (o_ss_n && !o_sclk)[*4])
		else $error("width change did not abort");
	a_dma_gate: assert property (
		!(opt_sh[OPT_TXDMA] && ctl_sh[CTL_ENABLE]) |-> !o_tx_dma_req)
		else $error("dma request without enables");
	a_slave_pin: assert property (
		!ctl_sh[CTL_MASTER] |-> !o_ss_oe && !o_ss_gpio)
		else $error("slave select pin not an input");
	a_gpio_free: assert property (
		ctl_sh[CTL_MASTER] && !opt_sh[OPT_MODF] |-> o_ss_gpio && !o_ss_oe)
		else $error("select pin not released");
	a_ss_drive: assert property (
		o_ss_oe |-> ctl_sh[CTL_ENABLE] && ctl_sh[CTL_MASTER]
		&& opt_sh[OPT_MODF] && ctl_sh[CTL_SELECT_OUTPUT_ENABLE])
		else $error("select output without enables");
endmodule
bind spiopt_core spiopt_chk u_chk (
	.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
	.i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
	.o_rd_data(o_rd_data), .o_irq(o_irq), .o_tx_dma_req(o_tx_dma_req),
	.o_sclk(o_sclk), .o_ss_n(o_ss_n), .o_ss_oe(o_ss_oe),
	.o_ss_gpio(o_ss_gpio)
);
`default_nettype wire

// ===== verif/spiopt_slave_model.sv
// behavioural spi slave device, mode 0, msb first
`timescale 1ns/1ps
`default_nettype none
module spiopt_slave_model (
	input  wire logic        i_sclk,
	input  wire logic        i_mosi,
	input  wire logic        i_sel_n,
	input  wire logic        i_wide,
	input  wire logic [15:0] i_tx_word,
	output logic             o_miso,
	output logic      [15:0] o_rx_word
);
	logic [15:0] sh;
	initial begin
		o_miso = 1'b0;
		o_rx_word = 16'h0000;
		sh = 16'h0000;
	end
	always @(negedge i_sel_n) begin
		sh = i_wide ? i_tx_word : {i_tx_word[7:0], 8'h00};
		o_miso = sh[15];
	end
	// released line flips so a stale bit is never mistaken for data
	always @(posedge i_sel_n) o_miso = ~o_miso;
	always @(posedge i_sclk) begin
		if (!i_sel_n) o_rx_word = {o_rx_word[14:0], i_mosi};
	end
	always @(negedge i_sclk) begin
		if (!i_sel_n) begin
			sh = {sh[14:0], 1'b0};
			o_miso = sh[15];
		end
	end
endmodule
`default_nettype wire

// ===== verif/spi_option_control_tb_top.sv
// self-checking bench for the spi option control block
`timescale 1ns/1ps
`default_nettype none
module spi_option_control_tb_top;
	import spiopt_pkg::*;
	logic        clk, arst_n, wr_en, rd_en, sclk_drv, mosi_drv, ss_drv_n;
	logic        wide, irq, dma, sclk_o, sclk_oe, mosi_o, mosi_oe;
	logic        miso_o, miso_oe, ss_o_n, ss_oe, ss_gpio, m_miso;
	logic [7:0]  addr, wdata, rdata, d;
	logic [15:0] tx_word, rx_word;
	int          n_errors, compares;
	wire logic   sclk_p, mosi_p, miso_p, ss_p;
	// pin level resolved from whoever drives it
	assign sclk_p = sclk_oe ? sclk_o : sclk_drv;
	assign mosi_p = mosi_oe ? mosi_o : mosi_drv;
	assign miso_p = miso_oe ? miso_o : m_miso;
	assign ss_p   = ss_oe ? ss_o_n : ss_drv_n;
	spiopt_core u_dut (
		.i_ref_clk(clk), .i_arst_n(arst_n), .i_addr(addr),
		.i_wr_data(wdata), .i_wr_en(wr_en), .i_rd_en(rd_en),
		.o_rd_data(rdata), .o_irq(irq), .o_tx_dma_req(dma),
		.i_sclk(sclk_p), .o_sclk(sclk_o), .o_sclk_oe(sclk_oe),
		.i_mosi(mosi_p), .o_mosi(mosi_o), .o_mosi_oe(mosi_oe),
		.i_miso(miso_p), .o_miso(miso_o), .o_miso_oe(miso_oe),
		.i_ss_n(ss_p), .o_ss_n(ss_o_n), .o_ss_oe(ss_oe),
		.o_ss_gpio(ss_gpio)
	);
	spiopt_slave_model u_far (
		.i_sclk(sclk_p), .i_mosi(mosi_p), .i_sel_n(ss_p), .i_wide(wide),
		.i_tx_word(tx_word), .o_miso(m_miso), .o_rx_word(rx_word)
	);
	always #10 clk = ~clk;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk(16'(v), 16'(e));
	endtask
	// bounded wait for one master frame to start and finish
	task automatic frame();
		int k;
		k = 0;
		while (ss_o_n !== 1'b0 && k < 40) begin
			@(posedge clk);
			k++;
		end
		while (ss_o_n !== 1'b1 && k < 400) begin
			@(posedge clk);
			k++;
		end
		repeat (3) @(posedge clk);
	endtask
	task automatic sbit(input logic b);
		mosi_drv <= b;
		repeat (4) @(posedge clk);
		sclk_drv <= 1'b1;
		repeat (4) @(posedge clk);
		sclk_drv <= 1'b0;
	endtask
	task automatic complete_run();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge clk);
		n_errors++;
		$display("mismatch at %0t: run hung", $time);
		complete_run();
	end
	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		{wr_en, rd_en, sclk_drv, mosi_drv, wide} = 5'h00;
		{addr, wdata, tx_word} = 32'h0000_0000;
		ss_drv_n = 1'b1;
		n_errors = 0;
		compares = 0;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		rc(OFS_OPTION, 8'h00);
		rc(8'h0F, 8'h00);
		wr(OFS_OPTION, 8'h0F);
		rc(OFS_OPTION, 8'h0F);
		wr(OFS_OPTION, 8'h20);
		#1 chk(16'(dma), 16'h0000);
		wr(OFS_CONTROL, 8'h80);
		#1 chk(16'(dma), 16'h0001);
		wr(OFS_OPTION, 8'h10);
		#1 chk(16'(dma), 16'h0000);
		// slave frame with fault enable set: select stays an input
		@(posedge clk);
		ss_drv_n <= 1'b0;
		repeat (4) @(posedge clk);
		#1 chk(16'({miso_oe, ss_oe}), 16'h0002);
		@(posedge clk);
		for (int i = 7; i >= 0; i--) sbit(1'(8'h3C >> i));
		repeat (8) @(posedge clk);
		ss_drv_n <= 1'b1;
		rc(OFS_DATA_LO, 8'h3C);
		wr(OFS_MATCH_LO, 8'h96);
		wr(OFS_IRQ_MASK, 8'h04);
		rd(OFS_IRQ_STATUS, d);
		wr(OFS_CONTROL, 8'h92);
		#1 chk(16'({ss_oe, ss_gpio}), 16'h0002);
		@(posedge clk);
		tx_word <= 16'h0096;
		wr(OFS_DATA_LO, 8'hA5);
		frame();
		chk(16'(rx_word[7:0]), 16'h00A5);
		rc(OFS_DATA_LO, 8'h96);
		chk(16'(irq), 16'h0000);
		wr(OFS_OPTION, 8'h90);
		#1 chk(16'(irq), 16'h0001);
		rd(OFS_IRQ_STATUS, d);
		chk(16'(d & 8'h04), 16'h0004);
		chk(16'(irq), 16'h0000);
		wr(OFS_OPTION, 8'h50);
		wide <= 1'b1;
		tx_word <= 16'hC35A;
		wr(OFS_DATA_HI, 8'h12);
		wr(OFS_DATA_LO, 8'h34);
		frame();
		chk(rx_word, 16'h1234);
		rc(OFS_DATA_HI, 8'hC3);
		rc(OFS_DATA_LO, 8'h5A);
		// width flip mid-frame must drop the frame at once
		wr(OFS_DATA_HI, 8'hAB);
		wr(OFS_DATA_LO, 8'hCD);
		repeat (20) @(posedge clk);
		wr(OFS_OPTION, 8'h10);
		repeat (2) @(posedge clk);
		#1 chk(16'({ss_o_n, sclk_o}), 16'h0002);
		rc(OFS_STATUS, 8'h20);
		wr(OFS_OPTION, 8'h00);
		#1 chk(16'({ss_gpio, ss_oe}), 16'h0002);
		// select pulled low in fault-input mode drops master, flags it
		wr(OFS_OPTION, 8'h10);
		wr(OFS_CONTROL, 8'h90);
		ss_drv_n <= 1'b0;
		repeat (4) @(posedge clk);
		ss_drv_n <= 1'b1;
		rc(OFS_STATUS, 8'h30);
		rc(OFS_CONTROL, 8'h80);
		wr(OFS_CONTROL, 8'h00);
		// reset in mid-run must clear a written option register
		wr(OFS_OPTION, 8'hAF);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		rc(OFS_OPTION, 8'h00);
		complete_run();
	end
endmodule
`default_nettype wire
